// ===== hdl/vpic_ctrl.sv
/*
  Vectored priority interrupt controller with APB register access.
  Assumes request inputs are synchronous to CORE_CLK and that the CPU
  pulses an acknowledge when it takes the presented vector.
*/
`timescale 1ns/1ps
module vpic_ctrl #(
  parameter int NUM_SRC = 72,
  parameter int NUM_EXT = 5
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [NUM_SRC-1:0] SRC_EVENT,
  input wire logic [NUM_EXT-1:0] EXT_PIN,
  input wire logic TRAP_LEVEL_IN,
  input wire logic CPU_ACK,
  output logic IRQ_REQ,
  output logic [6:0] VEC_NUM,
  output logic [3:0] VEC_LEVEL,
  output logic [23:0] VEC_ADDR
);
  import vpic_pkg::*;

  localparam int NWORDS = (NUM_SRC + SRC_PER_WORD - 1) / SRC_PER_WORD;
  localparam int NPRIO = (NUM_SRC + PRIO_PER_WORD - 1) / PRIO_PER_WORD;

  // ************************************************************
  // Decode helpers
  // ************************************************************
  // Request number of bit pos in flag or enable word idx
  function automatic int bank_src(input logic [9:0] idx, input int pos);
    return int'(idx) * SRC_PER_WORD + pos;
  endfunction : bank_src

  // Request number of slot pos in priority word idx
  function automatic int prio_src(input logic [9:0] idx, input int pos);
    return int'(idx) * PRIO_PER_WORD + pos;
  endfunction : prio_src

  // Aligned word inside a bank of nwords words starting at base
  function automatic logic in_bank(input logic [11:0] addr, input logic [11:0] base, input int nwords);
    logic [11:0] ofs;
    ofs = addr - base;
    return (addr >= base) && (int'(ofs[11:2]) < nwords) && (addr[1:0] == 2'b00);
  endfunction : in_bank

  // User priorities never reach the trap half of the level range
  function automatic logic [LEVEL_W-1:0] user_level(input logic [PRIO_W-1:0] prio);
    return LEVEL_W'(prio);
  endfunction : user_level

  // ************************************************************
  // Storage
  // ************************************************************
  logic [NUM_SRC-1:0] flag_reg;
  logic [NUM_SRC-1:0] flag_next;
  logic [NUM_SRC-1:0] enable_reg;
  logic [PRIO_W-1:0] prio_reg [NUM_SRC];
  logic [15:0] ctrl_a_reg;
  logic [15:0] ctrl_b_reg;
  logic [15:0] status_reg;
  logic trap_level_reg;
  logic [NUM_EXT-1:0] pin_reg;
  logic [6:0] vec_reg;
  logic [3:0] level_reg;
  logic [23:0] addr_reg;
  logic irq_reg;

  // ************************************************************
  // Bus decode
  // ************************************************************
  wire bus_access = PSEL && PENABLE;
  wire bus_wr = bus_access && PWRITE;
  wire [11:0] flag_ofs = PADDR - OFS_FLAG_BASE;
  wire [11:0] en_ofs = PADDR - OFS_ENABLE_BASE;
  wire [11:0] prio_ofs = PADDR - OFS_PRIO_BASE;
  wire [9:0] flag_idx = flag_ofs[11:2];
  wire [9:0] en_idx = en_ofs[11:2];
  wire [9:0] prio_idx = prio_ofs[11:2];
  wire in_flag = in_bank(PADDR, OFS_FLAG_BASE, NWORDS);
  wire in_en = in_bank(PADDR, OFS_ENABLE_BASE, NWORDS);
  wire in_prio = in_bank(PADDR, OFS_PRIO_BASE, NPRIO);
  wire hit_a = PADDR == OFS_CTRL_A;
  wire hit_b = PADDR == OFS_CTRL_B;
  wire hit_status = PADDR == OFS_STATUS;
  wire hit_core = PADDR == OFS_CORE;
  wire hit_pend = PADDR == OFS_PENDING;
  wire hit_addr = PADDR == OFS_ADDR;
  wire mapped = hit_a | hit_b | hit_status | hit_core | hit_pend | hit_addr | in_flag | in_en | in_prio;

  // Zero wait: every register answers in its access cycle
  assign PREADY = 1'b1;
  assign PSLVERR = bus_access && !mapped;

  // ************************************************************
  // Priority level and selection
  // ************************************************************
  // concatenated CPU level
  wire [3:0] cpu_level = {trap_level_reg, status_reg[LEVEL_LSB +: PRIO_W]};
  wire nest_off = ctrl_a_reg[NESTING_DISABLE_BIT];
  // level seven blocks; trap bit blocks
  wire user_block = trap_level_reg || (status_reg[LEVEL_LSB +: PRIO_W] == LEVEL_USER_OFF);

  logic [NUM_SRC-1:0] live;
  logic [PRIO_W-1:0] best_prio;
  logic [6:0] best_idx;
  logic best_any;

  assign live = flag_reg & enable_reg;

  // strict greater keeps the lower vector on ties
  always_comb begin
    best_prio = '0;
    best_idx = '0;
    best_any = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (live[i] && (!best_any || prio_reg[i] > best_prio)) begin
        best_prio = prio_reg[i];
        best_idx = 7'(i);
        best_any = 1'b1;
      end
    end
  end

  wire [6:0] best_vec = best_idx + VEC_BASE;
  // strictly above CPU level; if nesting off, no new pick while a request awaits ack
  wire allow = best_any && !user_block && (user_level(best_prio) > cpu_level) && !(nest_off && irq_reg);
  wire [23:0] table_base = ctrl_b_reg[ALT_TABLE_BIT] ? ALT_BASE : PRIMARY_BASE;
  wire [23:0] best_addr = table_base + (24'(best_vec) << ENTRY_SHIFT);

  // ************************************************************
  // External pin edges
  // ************************************************************
  logic [NUM_EXT-1:0] ext_edge;
  for (genvar p = 0; p < NUM_EXT; p++) begin : g_pin_edge
    wire rise = EXT_PIN[p] && !pin_reg[p];
    wire fall = !EXT_PIN[p] && pin_reg[p];
    // Changing polarity on a still pin makes no edge
    assign ext_edge[p] = ctrl_b_reg[p] ? fall : rise;
  end

  logic [NUM_SRC-1:0] hw_set;
  always_comb begin
    hw_set = SRC_EVENT;
    for (int e = 0; e < NUM_EXT; e++) begin
      if (EXT_REQ_IDX[e] < NUM_SRC) begin
        hw_set[EXT_REQ_IDX[e]] = SRC_EVENT[EXT_REQ_IDX[e]] | ext_edge[e];
      end
    end
  end

  // hardware sets, software clears; set wins
  // bank bit n is request n
  always_comb begin
    flag_next = flag_reg;
    if (bus_wr && in_flag) begin
      for (int b = 0; b < SRC_PER_WORD; b++) begin
        if (bank_src(flag_idx, b) < NUM_SRC) begin
          flag_next[bank_src(flag_idx, b)] = PWDATA[b];
        end
      end
    end
    flag_next = flag_next | hw_set;
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      flag_reg <= '0;
      enable_reg <= '0;
      ctrl_a_reg <= '0;
      ctrl_b_reg <= '0;
      status_reg <= STATUS_RESET;
      trap_level_reg <= 1'b0;
      pin_reg <= '0;
    end else begin
      flag_reg <= flag_next;
      pin_reg <= EXT_PIN;
      // trap bit follows core, never the bus
      trap_level_reg <= TRAP_LEVEL_IN;
      if (bus_wr && hit_a) begin
        ctrl_a_reg <= PWDATA[15:0] & CTRL_A_MASK;
      end
      if (bus_wr && hit_b) begin
        ctrl_b_reg <= PWDATA[15:0] & CTRL_B_MASK;
      end
      // software writes CPU level; frozen when nesting off
      if (bus_wr && hit_status) begin
        status_reg[15:8] <= PWDATA[15:8];
        status_reg[4:0] <= PWDATA[4:0];
        if (!nest_off) begin
          status_reg[LEVEL_LSB +: PRIO_W] <= PWDATA[LEVEL_LSB +: PRIO_W];
        end
      end
      if (bus_wr && in_en) begin
        for (int b = 0; b < SRC_PER_WORD; b++) begin
          if (bank_src(en_idx, b) < NUM_SRC) begin
            enable_reg[bank_src(en_idx, b)] <= PWDATA[b];
          end
        end
      end
    end
  end

  // three-bit field per source, four per word
  always_ff @(posedge CORE_CLK) begin
    for (int s = 0; s < NUM_SRC; s++) begin
      if (RESET) begin
        prio_reg[s] <= '0;
      end else if (bus_wr && in_prio && (s / PRIO_PER_WORD == int'(prio_idx))) begin
        prio_reg[s] <= PWDATA[(s % PRIO_PER_WORD) * PRIO_STRIDE +: PRIO_W];
      end
    end
  end

  // latch vector and level; level is source priority
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      vec_reg <= '0;
      level_reg <= '0;
      addr_reg <= '0;
      irq_reg <= 1'b0;
    end else if (CPU_ACK && irq_reg) begin
      irq_reg <= 1'b0;
    end else if (allow && !irq_reg) begin
      // One vector at a time; a newer pick waits for the ack
      vec_reg <= best_vec;
      level_reg <= user_level(best_prio);
      addr_reg <= best_addr;
      irq_reg <= 1'b1;
    end
  end

  // ************************************************************
  // Read mux
  // ************************************************************
  logic [15:0] rd_word;
  always_comb begin
    rd_word = '0;
    if (hit_a) begin
      rd_word = ctrl_a_reg;
    end else if (hit_b) begin
      rd_word = ctrl_b_reg;
    end else if (hit_status) begin
      rd_word = status_reg;
    end else if (hit_core) begin
      rd_word = 16'(trap_level_reg) << TRAP_LEVEL_BIT;
    end else if (hit_pend) begin
      rd_word = {4'h0, level_reg, 1'b0, vec_reg};
    end else if (hit_addr) begin
      rd_word = addr_reg[15:0];
    end else if (in_flag) begin
      for (int b = 0; b < SRC_PER_WORD; b++) begin
        if (bank_src(flag_idx, b) < NUM_SRC) begin
          rd_word[b] = flag_reg[bank_src(flag_idx, b)];
        end
      end
    end else if (in_en) begin
      for (int b = 0; b < SRC_PER_WORD; b++) begin
        if (bank_src(en_idx, b) < NUM_SRC) begin
          rd_word[b] = enable_reg[bank_src(en_idx, b)];
        end
      end
    end else if (in_prio) begin
      for (int k = 0; k < PRIO_PER_WORD; k++) begin
        if (prio_src(prio_idx, k) < NUM_SRC) begin
          rd_word[k * PRIO_STRIDE +: PRIO_W] = prio_reg[prio_src(prio_idx, k)];
        end
      end
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Read data is combinational so a zero-wait access can return it
  assign PRDATA = {16'h0000, rd_word};
  assign IRQ_REQ = irq_reg;
  assign VEC_NUM = vec_reg;
  assign VEC_LEVEL = level_reg;
  assign VEC_ADDR = addr_reg;

endmodule : vpic_ctrl

// ===== hdl/vpic_pkg.sv
/*
  Constants for the vectored priority interrupt controller: register map,
  field positions, reset values and vector numbering.
  Assumes an APB master with 32-bit data; each register is one aligned word.
*/
// Overview of operation
// - One sticky flag per source, software clears
// - Enable bit gates each pending flag
// - Three-bit priority field per user source
// - Bank bit order follows vector table order
// - Vector number equals request number plus eight
// - Two-byte entries in primary and alternate tables
// - Latch vector number and level when selected
// - Latched level equals selected source priority
// - Control A holds nesting disable, trap flags
// - Control B holds pin polarity, table select
// - Status word bits 7-5 hold CPU level
// - CPU level is trap bit over status bits
// - Trap level bit read-only to software
// - CPU level seven blocks user interrupts
// - Trap level bit set blocks user interrupts
// - Nesting disable freezes level bits to software
// - Lower vector wins among equal priorities
// - Table select picks alternate vector table
// - Polarity one falling edge, zero rising edge
package vpic_pkg;

  // ************************************************************
  // Register byte offsets (own choice of layout)
  // ************************************************************
  localparam logic [11:0] OFS_CTRL_A = 12'h000;
  localparam logic [11:0] OFS_CTRL_B = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_CORE = 12'h00C;
  localparam logic [11:0] OFS_PENDING = 12'h010;
  localparam logic [11:0] OFS_ADDR = 12'h014;
  localparam logic [11:0] OFS_FLAG_BASE = 12'h100;
  localparam logic [11:0] OFS_ENABLE_BASE = 12'h200;
  localparam logic [11:0] OFS_PRIO_BASE = 12'h300;

  // ************************************************************
  // Field positions and widths
  // ************************************************************
  localparam int NESTING_DISABLE_BIT = 15;
  localparam int ALT_TABLE_BIT = 15;
  localparam int LEVEL_LSB = 5;
  localparam int TRAP_LEVEL_BIT = 3;
  localparam int PRIO_W = 3;
  localparam int LEVEL_W = 4;
  localparam int VEC_W = 7;
  localparam int SRC_PER_WORD = 16;
  localparam int PRIO_PER_WORD = 4;
  localparam int PRIO_STRIDE = 4;
  localparam logic [15:0] CTRL_A_MASK = 16'hFFFE;
  localparam logic [15:0] CTRL_B_MASK = 16'h801F;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [2:0] LEVEL_USER_OFF = 3'h7;

  // ************************************************************
  // Vector numbering and table addresses
  // ************************************************************
  localparam logic [6:0] VEC_BASE = 7'h08;
  localparam logic [23:0] PRIMARY_BASE = 24'h00_0004;
  localparam logic [23:0] ALT_BASE = 24'h00_0104;
  localparam int ENTRY_SHIFT = 1;
  // Request numbers that belong to the external pins, pin 0 first
  localparam int EXT_REQ_IDX [5] = '{0, 20, 29, 53, 54};

endpackage : vpic_pkg

// ===== sim/vpic_cpu_model.sv
/*
  CPU side model: acknowledges a pending request after a set delay.
  Assumes delay 255 is used to stall while the bench inspects state.
*/
`timescale 1ns/1ps
module vpic_cpu_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic irq_req,
  input wire logic [7:0] ack_delay,
  output logic cpu_ack
);
  logic [7:0] wait_reg;
  // One-cycle ack; counter restarts so a re-raise waits again
  always_ff @(posedge clk) begin
    if (rst || !irq_req || cpu_ack) begin
      wait_reg <= 8'h00;
      cpu_ack <= 1'b0;
    end else begin
      wait_reg <= wait_reg + 8'h01;
      // Delay 255 never acks, so the bench can hold a request
      cpu_ack <= (ack_delay != 8'hFF) && (wait_reg >= ack_delay);
    end
  end
endmodule : vpic_cpu_model

// ===== sim/vpic_ctrl_checker.sv
/*
  Port checker for vpic_ctrl.
  Assumes binding to the top module's ports, one clock domain.
*/
`timescale 1ns/1ps
module vpic_ctrl_checker (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic TRAP_LEVEL_IN,
  input wire logic CPU_ACK,
  input wire logic IRQ_REQ,
  input wire logic [6:0] VEC_NUM,
  input wire logic [3:0] VEC_LEVEL,
  input wire logic [23:0] VEC_ADDR
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  // ********
  // Request handshake
  // ********
  sequence s_held;
    IRQ_REQ && !CPU_ACK;
  endsequence
  sequence s_taken;
    IRQ_REQ && CPU_ACK;
  endsequence
  chk_irq_holds: assert property (s_held |=> IRQ_REQ)
    else $error("request dropped without ack");
  chk_vec_stable: assert property (s_held |=> $stable(VEC_NUM) && $stable(VEC_ADDR))
    else $error("vector moved while pending");
  chk_level_stable: assert property (s_held |=> $stable(VEC_LEVEL))
    else $error("level moved while pending");
  chk_ack_clears: assert property (s_taken |=> !IRQ_REQ)
    else $error("request kept after ack");
  chk_vec_range: assert property (IRQ_REQ |-> VEC_NUM >= 7'd8 && VEC_NUM <= 7'd79)
    else $error("vector outside user range");
  chk_addr_map: assert property (IRQ_REQ |-> VEC_ADDR[7:0] == {VEC_NUM, 1'b0} + 8'h04 && VEC_ADDR[23:9] == 0)
    else $error("vector address not base plus twice vector");
  chk_level_user: assert property (IRQ_REQ |-> VEC_LEVEL inside {[1:7]})
    else $error("level outside user range");
  chk_trap_blocks: assert property ($rose(IRQ_REQ) |-> !($past(TRAP_LEVEL_IN) && $past(TRAP_LEVEL_IN, 2)))
    else $error("request raised under trap level");
endmodule : vpic_ctrl_checker

// ===== sim/vpic_ctrl_tb.sv
/*
  Self-checking bench for vpic_ctrl over APB with a CPU ack model.
  Assumes an APB slave that may stretch access, and the map of vpic_pkg.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; $display("mismatch %s exp %h got %h", n, e, g); end end
module vpic_ctrl_tb;
  import vpic_pkg::*;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, trap = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, cpu_ack, irq_req, err;
  logic [71:0] src = 0;
  logic [4:0] ext = 0;
  logic [6:0] vec_num;
  logic [3:0] vec_level;
  logic [23:0] vec_addr;
  logic [7:0] dly = 8'hFF;
  int error_cnt = 0, n_compared = 0;
  always #25 clk = ~clk;
  vpic_ctrl DUT (.CORE_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SRC_EVENT(src), .EXT_PIN(ext),
    .TRAP_LEVEL_IN(trap), .CPU_ACK(cpu_ack), .IRQ_REQ(irq_req), .VEC_NUM(vec_num),
    .VEC_LEVEL(vec_level), .VEC_ADDR(vec_addr));
  vpic_cpu_model cpu (.clk(clk), .rst(rst), .irq_req(irq_req), .ack_delay(dly), .cpu_ack(cpu_ack));
  // ********
  // Bus and helper tasks
  // ********
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0000, d});
  endtask : wr
  task automatic rchk(input string nm, input logic [11:0] a, input logic [15:0] e, input logic [15:0] m);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(nm, e, rd[15:0] & m)
  endtask : rchk
  task automatic irq(input logic [6:0] v, input logic [3:0] l, input logic [23:0] a);
    int n;
    n = 0;
    do @(negedge clk); while (irq_req !== 1'b1 && ++n < 50);
    `CHK("irq", 1'b1, irq_req)
    `CHK("vec", v, vec_num)
    `CHK("lvl", l, vec_level)
    `CHK("addr", a, vec_addr)
  endtask : irq
  // Let the model ack, then stall it again for the next request
  task automatic ack;
    int n;
    n = 0;
    dly <= 8'h00;
    do @(negedge clk); while (irq_req !== 1'b0 && ++n < 50);
    `CHK("acked", 1'b0, irq_req)
    @(posedge clk);
    dly <= 8'hFF;
  endtask : ack
  task automatic quiet;
    repeat (8) @(negedge clk);
    `CHK("quiet", 1'b0, irq_req)
    @(posedge clk);
  endtask : quiet
  task automatic pulse(input logic [71:0] m);
    src <= m;
    @(posedge clk);
    src <= '0;
    repeat (3) @(posedge clk);
  endtask : pulse
  task automatic pin(input logic v);
    ext[0] <= v;
    repeat (4) @(posedge clk);
  endtask : pin
  // ********
  // Scenarios
  // ********
  task automatic t_regs;
    rchk("status", OFS_STATUS, 16'h0000, 16'hFFFF);
    `CHK("okay", 1'b0, err)
    rchk("unmapped", 12'h0FC, 16'h0000, 16'hFFFF);
    `CHK("slverr", 1'b1, err)
    wr(OFS_CTRL_A, 16'hFFFF);
    rchk("ctrl_a", OFS_CTRL_A, CTRL_A_MASK, 16'hFFFF);
    wr(OFS_STATUS, 16'h00E0);
    rchk("frozen", OFS_STATUS, 16'h0000, 16'h00E0);
    wr(OFS_CTRL_A, 16'h0000);
    wr(OFS_STATUS, 16'h00E0);
    rchk("level", OFS_STATUS, 16'h00E0, 16'h00E0);
    wr(OFS_STATUS, 16'h0000);
    wr(OFS_CTRL_B, 16'hFFFF);
    rchk("ctrl_b", OFS_CTRL_B, CTRL_B_MASK, 16'hFFFF);
    wr(OFS_CTRL_B, 16'h0000);
    wr(OFS_CORE, 16'hFFFF);
    rchk("trap_ro", OFS_CORE, 16'h0000, 16'h0008);
    trap <= 1'b1;
    rchk("trap_in", OFS_CORE, 16'h0008, 16'h0008);
    trap <= 1'b0;
    $display("t_regs done");
  endtask : t_regs
  task automatic t_arb;
    wr(12'h300, 16'h4000);
    wr(12'h304, 16'h0040);
    wr(12'h344, 16'h0600);
    wr(12'h200, 16'h0028);
    wr(12'h210, 16'h0040);
    pulse({8'h40, 64'h28});
    irq(7'd78, 4'd6, 24'h00_00A0);
    rchk("pending", OFS_PENDING, 16'h064E, 16'h0FFF);
    wr(12'h110, 16'h0000);
    ack();
    irq(7'd11, 4'd4, 24'h00_001A);
    wr(12'h100, 16'h0020);
    ack();
    irq(7'd13, 4'd4, 24'h00_001E);
    wr(12'h100, 16'h0000);
    ack();
    quiet();
    $display("t_arb done");
  endtask : t_arb
  task automatic t_mask;
    wr(12'h300, 16'h7000);
    wr(12'h200, 16'h0000);
    pulse(72'h8);
    quiet();
    rchk("flag", 12'h100, 16'h0008, 16'hFFFF);
    wr(OFS_STATUS, 16'h00E0);
    wr(12'h200, 16'h0008);
    quiet();
    trap <= 1'b1;
    wr(OFS_STATUS, 16'h0000);
    quiet();
    trap <= 1'b0;
    irq(7'd11, 4'd7, 24'h00_001A);
    wr(12'h100, 16'h0000);
    ack();
    quiet();
    $display("t_mask done");
  endtask : t_mask
  task automatic t_ext;
    wr(OFS_CTRL_B, 16'h8000);
    wr(12'h300, 16'h0001);
    wr(12'h200, 16'h0001);
    pin(1'b1);
    irq(7'd8, 4'd1, 24'h00_0114);
    wr(12'h100, 16'h0000);
    pin(1'b0);
    rchk("fall0", 12'h100, 16'h0000, 16'h0001);
    wr(OFS_CTRL_B, 16'h8001);
    wr(12'h100, 16'h0000);
    pin(1'b1);
    rchk("rise1", 12'h100, 16'h0000, 16'h0001);
    pin(1'b0);
    rchk("fall1", 12'h100, 16'h0001, 16'h0001);
    wr(12'h100, 16'h0000);
    wr(OFS_CTRL_B, 16'h0000);
    ack();
    quiet();
    $display("t_ext done");
  endtask : t_ext
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_arb();
    t_mask();
    t_ext();
    report_and_stop();
  end
  // Run needs about 250 cycles
  initial begin
    #250000;
    error_cnt++;
    report_and_stop();
  end
endmodule : vpic_ctrl_tb
bind vpic_ctrl vpic_ctrl_checker u_chk (.CORE_CLK(CORE_CLK), .RESET(RESET), .TRAP_LEVEL_IN(TRAP_LEVEL_IN),
  .CPU_ACK(CPU_ACK), .IRQ_REQ(IRQ_REQ), .VEC_NUM(VEC_NUM), .VEC_LEVEL(VEC_LEVEL), .VEC_ADDR(VEC_ADDR));
